/* rtl/tqf_skid_buffer.v */
module tqf_skid_buffer (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       reset_i,
  input  wire       flush_i,
  // Filling side
  input  wire       in_valid_i,
  output wire       in_ready_o,
  input  wire [7:0] in_data_i,
  // Draining side
  output wire       out_valid_o,
  input  wire       out_ready_i,
  output wire [7:0] out_data_o
);

  reg  [7:0] slot_q [0:1];
  reg        wr_sel_q;
  reg        rd_sel_q;
  reg  [1:0] count_q;
  wire       push;
  wire       pop;

  assign in_ready_o  = (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o  = slot_q[rd_sel_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      slot_q[wr_sel_q] <= in_data_i;
    end
  end

  // A flush drops both slots so a queue clear leaves nothing stale for the modulator.
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_sel_q <= 1'b0;
      rd_sel_q <= 1'b0;
      count_q  <= 2'h0;
    end else if (flush_i) begin
      wr_sel_q <= 1'b0;
      rd_sel_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) begin
        wr_sel_q <= ~wr_sel_q;
      end
      if (pop) begin
        rd_sel_q <= ~rd_sel_q;
      end
      case ({push, pop})
        2'b10:   count_q <= count_q + 2'h1;
        2'b01:   count_q <= count_q - 2'h1;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule // tqf_skid_buffer

/* rtl/tqf_tx_queue.v */
`include "tqf_map.vh"

module tqf_tx_queue (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       reset_i,
  // Serial peripheral interface, mode 0
  input  wire       spi_nsel_n_i,
  input  wire       spi_sck_i,
  input  wire       spi_sdi_i,
  output wire       spi_sdo_o,
  // Operating mode control
  input  wire       tx_enter_i,
  input  wire       tx_leave_i,
  input  wire       idle_on_empty_i,
  output wire       tx_active_o,
  // Interrupts
  input  wire       irq_af_enable_i,
  input  wire       irq_ae_enable_i,
  input  wire [1:0] irq_clear_i,
  output wire       irq_af_status_o,
  output wire       irq_ae_status_o,
  output wire       interrupt_pin_n_o,
  // Queue state
  output wire [6:0] fill_level_o,
  // Modulator side
  output wire       mod_valid_o,
  input  wire       mod_ready_i,
  output wire [7:0] mod_data_o
);

  localparam ST_READY = 1'b0;
  localparam ST_TX    = 1'b1;

  // Serial interface state.
  reg        sck_q;
  reg  [2:0] bit_cnt_q;
  reg  [7:0] rx_shift_q;
  reg  [7:0] tx_shift_q;
  reg        addr_phase_q;
  reg        write_q;
  reg  [6:0] addr_q;
  reg        load_q;
  wire       sck_rise;
  wire       sck_fall;
  wire       byte_done;
  wire [7:0] byte_in;
  wire       wr_stb;
  reg  [7:0] rd_data;
  wire       hit_ctrl2;
  wire       hit_afull;
  wire       hit_aempty;
  wire       hit_queue;

  // Registers.
  reg        autotx_q;
  reg  [5:0] afull_level_q;
  reg  [5:0] aempty_level_q;

  // Queue storage.
  reg  [7:0] mem_q [0:63];
  reg  [5:0] wr_ptr_q;
  reg  [5:0] rd_ptr_q;
  reg  [6:0] mem_count_q;
  reg  [6:0] level_q;
  reg  [6:0] level_d;
  wire       queue_clear;
  wire       push;
  wire       pop;
  wire       buf_in_ready;
  wire       take;

  // Mode and events.
  reg        state_q;
  reg        state_d;
  wire [1:0] evt_hit;
  wire [1:0] evt_enable;
  wire [1:0] evt_status;
  wire       af_hit;
  wire       ae_hit;

  assign sck_rise  = ~spi_nsel_n_i & spi_sck_i & ~sck_q;
  assign sck_fall  = ~spi_nsel_n_i & ~spi_sck_i & sck_q;
  assign byte_done = sck_rise & (bit_cnt_q == 3'h7);
  assign byte_in   = {rx_shift_q[6:0], spi_sdi_i};
  assign wr_stb    = byte_done & ~addr_phase_q & write_q;
  assign spi_sdo_o = tx_shift_q[7];

  assign hit_ctrl2  = (addr_q == `TQF_ADDR_CTRL2);
  assign hit_afull  = (addr_q == `TQF_ADDR_AFULL);
  assign hit_aempty = (addr_q == `TQF_ADDR_AEMPTY);
  assign hit_queue  = (addr_q == `TQF_ADDR_QUEUE);

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sck_q        <= 1'b0;
      bit_cnt_q    <= 3'h0;
      rx_shift_q   <= 8'h00;
      tx_shift_q   <= 8'h00;
      addr_phase_q <= 1'b1;
      write_q      <= 1'b0;
      addr_q       <= 7'h00;
      load_q       <= 1'b0;
    end else begin
      sck_q <= spi_sck_i;
      if (spi_nsel_n_i) begin
        bit_cnt_q    <= 3'h0;
        addr_phase_q <= 1'b1;
        load_q       <= 1'b0;
      end else begin
        if (sck_rise) begin
          rx_shift_q <= byte_in;
          bit_cnt_q  <= bit_cnt_q + 3'h1;
        end
        if (byte_done) begin
          load_q <= 1'b1;
          if (addr_phase_q) begin
            addr_phase_q <= 1'b0;
            write_q      <= byte_in[7];
            addr_q       <= byte_in[6:0];
          end else if (addr_q != `TQF_ADDR_QUEUE) begin
            // The queue port holds its address so a burst keeps feeding the queue.
            addr_q <= addr_q + 7'h01;
          end
        end
        if (sck_fall) begin
          load_q <= 1'b0;
          if (load_q) begin
            tx_shift_q <= rd_data;
          end else begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // The queue port is write-only, and the clear bit reads back as zero.
  always @* begin
    case (addr_q)
      `TQF_ADDR_CTRL2:  rd_data = {4'h0, autotx_q, 3'h0};
      `TQF_ADDR_AFULL:  rd_data = {2'h0, afull_level_q};
      `TQF_ADDR_AEMPTY: rd_data = {2'h0, aempty_level_q};
      default:          rd_data = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      autotx_q       <= `TQF_RST_AUTOTX;
      afull_level_q  <= `TQF_RST_AFULL;
      aempty_level_q <= `TQF_RST_AEMPTY;
    end else if (wr_stb) begin
      if (hit_ctrl2) begin
        autotx_q <= byte_in[`TQF_BIT_AUTOTX];
      end
      if (hit_afull) begin
        afull_level_q <= byte_in[5:0];
      end
      if (hit_aempty) begin
        aempty_level_q <= byte_in[5:0];
      end
    end
  end

  // Clear is an action, not a stored bit, so software need not write it back to zero.
  assign queue_clear = wr_stb & hit_ctrl2 & byte_in[`TQF_BIT_QCLEAR];
  // Bytes beyond the capacity are dropped; the buffer slots count toward it.
  assign push = wr_stb & hit_queue & (level_q != `TQF_DEPTH) & ~queue_clear;
  assign pop  = (state_q == ST_TX) & buf_in_ready & (mem_count_q != 7'h00) & ~queue_clear;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= byte_in;
    end
  end

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_q    <= 6'h00;
      rd_ptr_q    <= 6'h00;
      mem_count_q <= 7'h00;
    end else if (queue_clear) begin
      wr_ptr_q    <= 6'h00;
      rd_ptr_q    <= 6'h00;
      mem_count_q <= 7'h00;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 6'h01;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 6'h01;
      end
      case ({push, pop})
        2'b10:   mem_count_q <= mem_count_q + 7'h01;
        2'b01:   mem_count_q <= mem_count_q - 7'h01;
        default: mem_count_q <= mem_count_q;
      endcase
    end
  end

  // Two slots decouple the modulator from the storage read, so a stall loses no byte.
  tqf_skid_buffer u_skid (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .flush_i     (queue_clear),
    .in_valid_i  (pop),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (mem_q[rd_ptr_q]),
    .out_valid_o (mod_valid_o),
    .out_ready_i (mod_ready_i),
    .out_data_o  (mod_data_o)
  );

  assign take = mod_valid_o & mod_ready_i;

  always @* begin
    level_d = level_q;
    if (queue_clear) begin
      level_d = 7'h00;
    end else if (push & ~take) begin
      level_d = level_q + 7'h01;
    end else if (take & ~push) begin
      level_d = level_q - 7'h01;
    end
  end

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      level_q <= 7'h00;
    end else begin
      level_q <= level_d;
    end
  end

  // Events fire on arrival at the level, not while sitting on it.
  assign af_hit = push & ~take & (level_d == {1'b0, afull_level_q});
  assign ae_hit = take & ~push & (level_d == {1'b0, aempty_level_q});

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_READY: begin
        if (tx_enter_i | (autotx_q & af_hit)) begin
          state_d = ST_TX;
        end
      end
      ST_TX: begin
        if (tx_leave_i) begin
          state_d = ST_READY;
        end else if ((idle_on_empty_i | autotx_q) & (level_q == 7'h00)) begin
          state_d = ST_READY;
        end
      end
      default: state_d = ST_READY;
    endcase
  end

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // Bit 0 of each event vector is almost full, bit 1 almost empty.
  assign evt_hit    = {ae_hit, af_hit};
  assign evt_enable = {irq_ae_enable_i, irq_af_enable_i};

  genvar ev;
  generate
    for (ev = 0; ev < 2; ev = ev + 1) begin : g_event
      reg flag_q;
      // A new event in the cycle of its clear is kept, so no event is ever lost.
      always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
          flag_q <= 1'b0;
        end else begin
          flag_q <= evt_hit[ev] | (flag_q & ~irq_clear_i[ev]);
        end
      end
      assign evt_status[ev] = flag_q;
    end
  endgenerate

  assign interrupt_pin_n_o = ~|(evt_status & evt_enable);
  assign irq_af_status_o   = evt_status[0];
  assign irq_ae_status_o   = evt_status[1];
  assign tx_active_o       = state_q;
  assign fill_level_o      = level_q;

endmodule // tqf_tx_queue

/* shared/tqf_map.vh */
`ifndef TQF_MAP_VH
`define TQF_MAP_VH

`define TQF_ADDR_CTRL2      7'h08
`define TQF_ADDR_AFULL      7'h7C
`define TQF_ADDR_AEMPTY     7'h7D
`define TQF_ADDR_QUEUE      7'h7F

`define TQF_RST_AUTOTX      1'b0
`define TQF_RST_AFULL       6'h37
`define TQF_RST_AEMPTY      6'h04

`define TQF_BIT_AUTOTX      3
`define TQF_BIT_QCLEAR      0

`define TQF_DEPTH           7'h40

`endif

/* tb/tqf_spi_host.sv */
module tqf_spi_host (
  // System clock
  input  wire logic clk_sys_i,
  // Serial bus
  output logic      spi_nsel_n_o,
  output logic      spi_sck_o,
  output logic      spi_sdi_o,
  input  wire logic spi_sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q;
  initial {spi_nsel_n_o, spi_sck_o, spi_sdi_o} = 3'h4;
  // Each sck phase lasts two system clocks, one more than the sampler needs to see it.
  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      spi_sdi_o = b[i];
      repeat (2) @(posedge clk_sys_i);
      #2 spi_sck_o = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rx_q[i] = spi_sdo_i;
      #2 spi_sck_o = 1'b0;
    end
  endtask
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, input int n,
                      output logic [7:0] q);
    @(posedge clk_sys_i);
    #2 spi_nsel_n_o = 1'b0;
    shift({w, a});
    for (int k = 0; k < (w ? n : 1); k++) shift(d + k[7:0]);
    @(posedge clk_sys_i);
    #2 spi_nsel_n_o = 1'b1;
    spi_sdi_o = ~spi_sdi_o;
    q = rx_q;
  endtask
endmodule // tqf_spi_host

/* tb/tqf_tx_queue_checker.sv */
module tqf_tx_queue_checker (
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  // Watched ports
  input wire logic       tx_enter_i,
  input wire logic       tx_leave_i,
  input wire logic       idle_on_empty_i,
  input wire logic       tx_active_o,
  input wire logic       irq_af_enable_i,
  input wire logic       irq_ae_enable_i,
  input wire logic       irq_af_status_o,
  input wire logic       irq_ae_status_o,
  input wire logic       interrupt_pin_n_o,
  input wire logic [6:0] fill_level_o,
  input wire logic       mod_valid_o,
  input wire logic       mod_ready_i,
  input wire logic [7:0] mod_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_max; fill_level_o <= 7'h40; endproperty
  a_max: assert property (p_max) else $error("level above capacity");
  property p_pin;
    interrupt_pin_n_o != (irq_af_status_o & irq_af_enable_i | irq_ae_status_o & irq_ae_enable_i);
  endproperty
  a_pin: assert property (p_pin) else $error("pin mismatch");
  property p_af; $rose(irq_af_status_o) |-> fill_level_o == $past(fill_level_o) + 7'h01; endproperty
  a_af: assert property (p_af) else $error("almost full not on a write");
  property p_ae; $rose(irq_ae_status_o) |-> fill_level_o + 7'h01 == $past(fill_level_o); endproperty
  a_ae: assert property (p_ae) else $error("almost empty not on a take");
  property p_idle; tx_active_o && idle_on_empty_i && fill_level_o == 7'h00 |=> !tx_active_o; endproperty
  a_idle: assert property (p_idle) else $error("stayed in transmit");
  property p_leave; tx_active_o && tx_leave_i |=> !tx_active_o; endproperty
  a_leave: assert property (p_leave) else $error("leave ignored");
  property p_enter; !tx_active_o && tx_enter_i |=> tx_active_o; endproperty
  a_enter: assert property (p_enter) else $error("enter ignored");
  property p_first; $rose(tx_active_o) && fill_level_o != 7'h00 |-> ##1 mod_valid_o; endproperty
  a_first: assert property (p_first) else $error("first byte late");
  property p_hold;
    mod_valid_o && !mod_ready_i |=> mod_valid_o && $stable(mod_data_o) || fill_level_o == 7'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("stalled byte lost");
  c_af: cover property ($rose(irq_af_status_o));
  c_ae: cover property ($rose(irq_ae_status_o));
  c_full: cover property (fill_level_o == 7'h40);
endmodule // tqf_tx_queue_checker

bind tqf_tx_queue tqf_tx_queue_checker chk_u (.*);

/* tb/tx_byte_fifo_thresholds_test.sv */
module tx_byte_fifo_thresholds_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [6:0] a; logic w; logic [7:0] d; logic [7:0] e;} tqf_row_t;
  logic       clk_sys_i, reset_i, spi_nsel_n_i, spi_sck_i, spi_sdi_i, spi_sdo_o;
  logic       tx_enter_i, tx_leave_i, idle_on_empty_i, tx_active_o, mod_valid_o, mod_ready_i;
  logic       irq_af_enable_i, irq_ae_enable_i, irq_af_status_o, irq_ae_status_o;
  logic       interrupt_pin_n_o;
  logic [1:0] irq_clear_i;
  logic [6:0] fill_level_o;
  logic [7:0] mod_data_o, rd_v;
  int         err_count, compares, k, t;
  tqf_row_t   rows[8] = '{'{7'h08, 1'b0, 8'h00, 8'h00}, '{7'h7C, 1'b0, 8'h00, 8'h37},
    '{7'h7D, 1'b0, 8'h00, 8'h04}, '{7'h7C, 1'b1, 8'hEA, 8'h2A}, '{7'h7D, 1'b1, 8'hFF, 8'h3F},
    '{7'h08, 1'b1, 8'h08, 8'h08}, '{7'h20, 1'b1, 8'h5A, 8'h00}, '{7'h7F, 1'b0, 8'h00, 8'h00}};
  tqf_tx_queue dut_u (.*);
  tqf_spi_host host_u (.clk_sys_i(clk_sys_i), .spi_nsel_n_o(spi_nsel_n_i), .spi_sck_o(spi_sck_i),
    .spi_sdi_o(spi_sdi_i), .spi_sdo_i(spi_sdo_o));
  task automatic test_done;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask
  task automatic tick;
    @(posedge clk_sys_i);
    #2;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    host_u.xfer(1'b1, a, d, n, rd_v);
  endtask
  task automatic pulse_enter;
    tx_enter_i = 1'b1;
    tick;
    tx_enter_i = 1'b0;
  endtask
  task automatic wait_tx(input logic want);
    for (t = 0; tx_active_o !== want; t++) begin
      if (t == 200) begin
        fail("state wait");
        test_done;
      end
      tick;
    end
  endtask
  // The modulator stalls every third cycle so the two-slot buffer must hold its words.
  task automatic drain(input int n, input logic [7:0] b);
    k = 0;
    for (t = 0; k < n; t++) begin
      if (t == 500) begin
        fail("drain wait");
        test_done;
      end
      tick;
      mod_ready_i = (t % 3 != 0);
      @(negedge clk_sys_i);
      if (mod_valid_o && mod_ready_i) begin
        chk(mod_data_o, b + k[7:0], "byte order");
        k++;
      end
    end
    tick;
    mod_ready_i = 1'b0;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {reset_i, tx_enter_i, tx_leave_i, idle_on_empty_i} = 4'h8;
    {irq_af_enable_i, irq_ae_enable_i, mod_ready_i, irq_clear_i} = 5'h00;
    repeat (4) tick;
    reset_i = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, 1);
      host_u.xfer(1'b0, rows[i].a, 8'h00, 1, rd_v);
      chk(rd_v, rows[i].e, "register");
    end
    $display("test registers done");
    wr(7'h7F, 8'h33, 3);
    reset_i = 1'b1;
    tick;
    reset_i = 1'b0;
    chk(8'(fill_level_o), 8'h00, "level after reset");
    host_u.xfer(1'b0, 7'h7C, 8'h00, 1, rd_v);
    chk(rd_v, 8'h37, "threshold after reset");
    $display("test reset done");
    wr(7'h7C, 8'h05, 1);
    wr(7'h7D, 8'h02, 1);
    wr(7'h7F, 8'h10, 5);
    chk(8'(fill_level_o), 8'h05, "fill level");
    chk(8'(irq_af_status_o), 8'h01, "almost full");
    chk(8'(interrupt_pin_n_o), 8'h01, "masked pin");
    irq_af_enable_i = 1'b1;
    tick;
    chk(8'(interrupt_pin_n_o), 8'h00, "enabled pin");
    irq_clear_i = 2'b01;
    tick;
    irq_clear_i = 2'b00;
    chk(8'(irq_af_status_o), 8'h00, "status clear");
    idle_on_empty_i = 1'b1;
    pulse_enter;
    drain(5, 8'h10);
    chk(8'(irq_ae_status_o), 8'h01, "almost empty");
    chk(8'(interrupt_pin_n_o), 8'h01, "masked empty pin");
    irq_ae_enable_i = 1'b1;
    tick;
    chk(8'(interrupt_pin_n_o), 8'h00, "enabled empty pin");
    irq_clear_i = 2'b10;
    tick;
    irq_clear_i = 2'b00;
    chk(8'(irq_ae_status_o), 8'h00, "empty status clear");
    chk(8'(interrupt_pin_n_o), 8'h01, "pin released");
    repeat (2) tick;
    chk(8'(tx_active_o), 8'h00, "idle on empty");
    $display("test thresholds done");
    wr(7'h7F, 8'h40, 66);
    chk(8'(fill_level_o), 8'h40, "capacity");
    wr(7'h08, 8'h01, 1);
    chk(8'(fill_level_o), 8'h00, "queue clear");
    wr(7'h7F, 8'hA0, 2);
    pulse_enter;
    drain(2, 8'hA0);
    $display("test clear done");
    idle_on_empty_i = 1'b0;
    wr(7'h7C, 8'h03, 1);
    wr(7'h08, 8'h08, 1);
    wr(7'h7F, 8'hC0, 3);
    wait_tx(1'b1);
    drain(3, 8'hC0);
    wait_tx(1'b0);
    $display("test auto transmit done");
    wr(7'h08, 8'h00, 1);
    wr(7'h7F, 8'h01, 2);
    pulse_enter;
    tx_leave_i = 1'b1;
    tick;
    tx_leave_i = 1'b0;
    chk(8'(tx_active_o), 8'h00, "leave");
    repeat (2) tick;
    chk(mod_data_o, 8'h01, "held byte");
    chk(8'(mod_valid_o), 8'h01, "held valid");
    $display("test leave done");
    test_done;
  end
endmodule // tx_byte_fifo_thresholds_test
